//--- rtl/mdid_pkg.sv
// shared types and constants for the motor driver input decoder
package mdid_pkg;
    localparam int TERM_COUNT = 7;
    localparam int FUNC_BITS = 5;
    localparam int DATA_BITS = 4;
    localparam int FUNC_COUNT = 18;

    typedef enum logic [4:0] {
        FN_NONE = 5'h00,
        FN_FORWARD_RUN = 5'h01,
        FN_BACKWARD_RUN = 5'h02,
        FN_HALT_STYLE = 5'h03,
        FN_SEL0 = 5'h04,
        FN_SEL1 = 5'h05,
        FN_FAULT_CLEAR = 5'h06,
        FN_BRAKE_RELEASE = 5'h07,
        FN_RUN_GATE = 5'h08,
        FN_QUICK_HALT = 5'h09,
        FN_SPIN_SENSE = 5'h0a,
        FN_SEL2 = 5'h0b,
        FN_SEL3 = 5'h0c,
        FN_HOLD_DISABLE = 5'h0d,
        FN_TORQUE_CAP = 5'h0e,
        FN_NOTICE_CLEAR = 5'h0f,
        FN_PANEL_LOCKOUT = 5'h10,
        FN_OUTSIDE_FAULT = 5'h11
    } mdid_func_t;

    // shipped terminal functions, terminal 6 first
    localparam logic [34:0] DEFAULT_MAP = {
        FN_BRAKE_RELEASE, FN_FAULT_CLEAR, FN_SEL1, FN_SEL0, FN_HALT_STYLE, FN_BACKWARD_RUN, FN_FORWARD_RUN};

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_DECEL_STOP = 2'b10,
        ST_QUICK_STOP = 2'b11
    } mdid_state_t;

    typedef struct packed {
        logic run;
        logic ccw;
        logic decel_stop;
        logic quick_stop;
        logic [3:0] data_no;
    } mdid_cmd_t;

    typedef struct packed {
        logic brake_release;
        logic hold_disable;
        logic torque_limit;
        logic panel_locked;
        logic notice_clear;
        logic alarm_clear;
        logic ext_alarm;
    } mdid_aux_t;

    typedef struct packed {
        logic [6:0] sync1;
        logic [6:0] sync2;
        logic [17:0] func_prev;
        mdid_state_t state;
        mdid_cmd_t cmd;
        mdid_aux_t aux;
    } mdid_regs_t;
endpackage : mdid_pkg

//--- rtl/mdid_decoder.sv
// input terminal decoder turning driver inputs into motor commands
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - two-wire: either run input rotates motor
// - two-wire: releasing commanding run input stops
// - two-wire: run direction follows rotation direction parameter
// - two-wire: halt style picks decel or instant stop
// - two select bits pick four entries
// - four select bits pick sixteen entries
// - data number is binary of selects
// - fault clear clears present alarm
// - alarm clear acts on rising edge
// - brake release frees brake at standstill
// - three-wire: rotate while gate and halt on
// - three-wire: gate off decelerates to stop
// - three-wire: quick halt off stops instantly
// - three-wire: spin sense selects direction
// - spin sense on ccw, off cw
// - hold disable chooses load holding
// - normally open torque toggle limits torque
// - notice clear clears active information
// - normally open lockout restricts panel operation
// - outside fault off forces stop, alarm
// - parameter selects two- or three-wire mode
module mdid_decoder (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [6:0] term_in,
    input wire logic three_wire_mode,
    input wire logic fwd_is_ccw,
    input wire logic map_use_custom,
    input wire logic [34:0] term_func_map,
    input wire logic alarm_active,
    output logic run,
    output logic ccw,
    output logic decel_stop,
    output logic quick_stop,
    output logic [3:0] data_no,
    output logic alarm_clear,
    output logic ext_alarm,
    output logic brake_release,
    output logic hold_disable,
    output logic torque_limit,
    output logic panel_locked,
    output logic notice_clear
);
    mdid_pkg::mdid_regs_t r;
    mdid_pkg::mdid_regs_t next_r;
    logic [17:0] func_on;
    logic [34:0] map_sel;
    logic [3:0] sel_bits;

    assign map_sel = map_use_custom ? term_func_map : mdid_pkg::DEFAULT_MAP;

    // function levels gathered over terminals; unassigned functions read off
    always_comb begin
        func_on = '0;
        for (int t = 0; t < mdid_pkg::TERM_COUNT; t++) begin
            for (int f = 1; f < mdid_pkg::FUNC_COUNT; f++) begin
                if (map_sel[t*mdid_pkg::FUNC_BITS +: mdid_pkg::FUNC_BITS] == 5'(f) && r.sync2[t]) begin
                    func_on[f] = 1'b1;
                end
            end
        end
    end

    // unassigned upper bits read off, so two bits give four entries
    assign sel_bits = {func_on[mdid_pkg::FN_SEL3], func_on[mdid_pkg::FN_SEL2],
                       func_on[mdid_pkg::FN_SEL1], func_on[mdid_pkg::FN_SEL0]};

    always_comb begin
        logic forward_run;
        logic bwd;
        logic go;
        logic stopped;
        logic fault_stop;
        forward_run = 1'b0;
        bwd = 1'b0;
        go = 1'b0;
        stopped = 1'b0;
        fault_stop = 1'b0;
        next_r = r;
        next_r.sync1 = term_in;
        next_r.sync2 = r.sync1;
        next_r.func_prev = func_on;
        next_r.cmd.data_no = sel_bits;

        // outside fault is normally closed: an open line acts, but only where mapped
        if (!map_use_custom) begin
            fault_stop = 1'b0;
        end else begin
            fault_stop = 1'b0;
            for (int t = 0; t < mdid_pkg::TERM_COUNT; t++) begin
                if (map_sel[t*mdid_pkg::FUNC_BITS +: mdid_pkg::FUNC_BITS] == mdid_pkg::FN_OUTSIDE_FAULT
                    && !r.sync2[t]) begin
                    fault_stop = 1'b1;
                end
            end
        end
        next_r.aux.ext_alarm = r.aux.ext_alarm | fault_stop;

        if (three_wire_mode) begin
            go = func_on[mdid_pkg::FN_RUN_GATE] && func_on[mdid_pkg::FN_QUICK_HALT];
            next_r.cmd.ccw = func_on[mdid_pkg::FN_SPIN_SENSE];
        end else begin
            forward_run = func_on[mdid_pkg::FN_FORWARD_RUN];
            bwd = func_on[mdid_pkg::FN_BACKWARD_RUN];
            go = forward_run ^ bwd;
            if (forward_run && !bwd) begin
                next_r.cmd.ccw = fwd_is_ccw;
            end else if (bwd && !forward_run) begin
                next_r.cmd.ccw = !fwd_is_ccw;
            end
        end
        go = go && !r.aux.ext_alarm && !fault_stop && !alarm_active;

        unique case (r.state)
            mdid_pkg::ST_IDLE, mdid_pkg::ST_DECEL_STOP, mdid_pkg::ST_QUICK_STOP: begin
                if (go) begin
                    next_r.state = mdid_pkg::ST_RUN;
                end else if (r.state != mdid_pkg::ST_IDLE && !func_on[mdid_pkg::FN_FORWARD_RUN]
                             && !func_on[mdid_pkg::FN_BACKWARD_RUN] && !func_on[mdid_pkg::FN_RUN_GATE]) begin
                    next_r.state = mdid_pkg::ST_IDLE;
                end
            end
            mdid_pkg::ST_RUN: begin
                if (!go) begin
                    if (fault_stop || r.aux.ext_alarm || alarm_active) begin
                        next_r.state = mdid_pkg::ST_QUICK_STOP;
                    end else if (three_wire_mode) begin
                        next_r.state = func_on[mdid_pkg::FN_QUICK_HALT] ?
                            mdid_pkg::ST_DECEL_STOP : mdid_pkg::ST_QUICK_STOP;
                    end else begin
                        next_r.state = func_on[mdid_pkg::FN_HALT_STYLE] ?
                            mdid_pkg::ST_QUICK_STOP : mdid_pkg::ST_DECEL_STOP;
                    end
                end
            end
        endcase

        next_r.cmd.run = (next_r.state == mdid_pkg::ST_RUN);
        next_r.cmd.decel_stop = (next_r.state == mdid_pkg::ST_DECEL_STOP);
        next_r.cmd.quick_stop = (next_r.state == mdid_pkg::ST_QUICK_STOP);
        stopped = !next_r.cmd.run;

        // clear only on the off-to-on edge and only with go low and both two-wire run inputs off
        next_r.aux.alarm_clear = func_on[mdid_pkg::FN_FAULT_CLEAR] && !r.func_prev[mdid_pkg::FN_FAULT_CLEAR]
                                 && !go && !func_on[mdid_pkg::FN_FORWARD_RUN]
                                 && !func_on[mdid_pkg::FN_BACKWARD_RUN];
        if (next_r.aux.alarm_clear && !fault_stop) begin
            next_r.aux.ext_alarm = 1'b0;
        end
        next_r.aux.brake_release = func_on[mdid_pkg::FN_BRAKE_RELEASE] && stopped;
        next_r.aux.hold_disable = func_on[mdid_pkg::FN_HOLD_DISABLE];
        next_r.aux.torque_limit = func_on[mdid_pkg::FN_TORQUE_CAP];
        next_r.aux.panel_locked = func_on[mdid_pkg::FN_PANEL_LOCKOUT];
        next_r.aux.notice_clear = func_on[mdid_pkg::FN_NOTICE_CLEAR]
                                  && !r.func_prev[mdid_pkg::FN_NOTICE_CLEAR];
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign run = r.cmd.run;
    assign ccw = r.cmd.ccw;
    assign decel_stop = r.cmd.decel_stop;
    assign quick_stop = r.cmd.quick_stop;
    assign data_no = r.cmd.data_no;
    assign alarm_clear = r.aux.alarm_clear;
    assign ext_alarm = r.aux.ext_alarm;
    assign brake_release = r.aux.brake_release;
    assign hold_disable = r.aux.hold_disable;
    assign torque_limit = r.aux.torque_limit;
    assign panel_locked = r.aux.panel_locked;
    assign notice_clear = r.aux.notice_clear;
endmodule : mdid_decoder
`default_nettype wire

//--- testbench/mdid_switch_bank.sv
// switch bank standing in for the controller at the terminals
`timescale 1ns/1ps
`default_nettype none
module mdid_switch_bank (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic set_en,
    input wire logic [6:0] set_val,
    output logic [6:0] term_in
);
    // contacts hold their level until told otherwise
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            term_in <= 7'h00;
        end else if (set_en) begin
            term_in <= set_val;
        end
    end
endmodule : mdid_switch_bank
`default_nettype wire

//--- testbench/mdid_checker.sv
// port checker for the input decoder
`timescale 1ns/1ps
`default_nettype none
module mdid_checker (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [6:0] term_in,
    input wire logic three_wire_mode,
    input wire logic fwd_is_ccw,
    input wire logic map_use_custom,
    input wire logic alarm_active,
    input wire logic run,
    input wire logic ccw,
    input wire logic decel_stop,
    input wire logic quick_stop,
    input wire logic [3:0] data_no,
    input wire logic alarm_clear,
    input wire logic brake_release
);
    // history seen by $past is unknown until a few cycles after reset
    logic [2:0] warm;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            warm <= 3'h0;
        end else if (warm != 3'h4) begin
            warm <= warm + 3'h1;
        end
    end
    default clocking dc @(posedge clk_sys); endclocking
    default disable iff (rst || warm != 3'h4);
    // three cycles: two sync flops plus the output register
    property p_sel4;
        !map_use_custom |-> data_no == {2'b00, $past(term_in[4:3], 3)};
    endproperty
    a_sel4: assert property (p_sel4) else $error("data number wrong");
    property p_sel16;
        map_use_custom && three_wire_mode |-> data_no == $past(term_in[6:3], 3);
    endproperty
    a_sel16: assert property (p_sel16) else $error("wide data number wrong");
    property p_two_run;
        !three_wire_mode && !map_use_custom && ^$past(term_in[1:0], 3) && !alarm_active
            |-> run && ccw == (fwd_is_ccw ^ $past(term_in[1], 3));
    endproperty
    a_two_run: assert property (p_two_run) else $error("two-wire run wrong");
    property p_two_stop;
        $fell(run) && !three_wire_mode && !map_use_custom && $past(term_in[1:0], 3) == 2'b00
            |-> quick_stop == $past(term_in[2], 3) && decel_stop == !quick_stop;
    endproperty
    a_two_stop: assert property (p_two_stop) else $error("two-wire stop wrong");
    property p_three_run;
        three_wire_mode && map_use_custom && $past(term_in[1:0], 3) == 2'b11 && !alarm_active
            |-> run && ccw == $past(term_in[2], 3);
    endproperty
    a_three_run: assert property (p_three_run) else $error("three-wire run wrong");
    property p_three_stop;
        $fell(run) && three_wire_mode && ^$past(term_in[1:0], 3)
            |-> quick_stop == !$past(term_in[1], 3) && decel_stop == !quick_stop;
    endproperty
    a_three_stop: assert property (p_three_stop) else $error("three-wire stop wrong");
    property p_clear;
        alarm_clear && !map_use_custom |-> $past(term_in[5], 3) && !$past(term_in[5], 4) ##1 !alarm_clear;
    endproperty
    a_clear: assert property (p_clear) else $error("alarm clear wrong");
    property p_brake;
        brake_release |-> !run;
    endproperty
    a_brake: assert property (p_brake) else $error("brake freed while running");
    c_run: cover property (run ##1 !run);
    c_clear: cover property (alarm_clear);
    c_quick: cover property (quick_stop);
endmodule : mdid_checker
bind mdid_decoder mdid_checker mdid_checker_inst (.*);
`default_nettype wire

//--- testbench/mdid_decoder_tb_top.sv
// testbench top for the input decoder
`timescale 1ns/1ps
`default_nettype none
module mdid_decoder_tb_top;
    logic clk_sys = 0, rst = 1, set_en = 0, three_wire_mode = 0, fwd_is_ccw = 0;
    logic map_use_custom = 0, alarm_active = 0, run, ccw, decel_stop, quick_stop, alarm_clear;
    logic ext_alarm, brake_release, hold_disable, torque_limit, panel_locked, notice_clear;
    logic [6:0] set_val = 7'h00, term_in;
    logic [3:0] data_no, clr_n = 4'h0, note_n = 4'h0;
    logic [34:0] term_func_map = 35'h0;
    int error_cnt = 0, n_tests = 0;
    mdid_decoder mdid_decoder_inst (.*);
    mdid_switch_bank mdid_switch_bank_inst (.*);
    initial forever #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        clr_n <= clr_n + {3'h0, alarm_clear};
        note_n <= note_n + {3'h0, notice_clear};
    end
    task automatic check(input logic [3:0] seen, input logic [3:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check
    // one request, then long enough for the three-cycle path
    task automatic put(input logic [6:0] v);
        set_val <= v;
        set_en <= 1'b1;
        @(posedge clk_sys);
        set_en <= 1'b0;
        repeat (5) @(posedge clk_sys);
    endtask : put
    task automatic give_verdict;
        $display("errors %0d, checks %0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : give_verdict
    initial begin
        #20us;
        error_cnt++;
        give_verdict();
    end
    initial begin
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        for (int f = 0; f < 2; f++) begin
            fwd_is_ccw <= f[0];
            put(7'h01);
            check({2'b00, run, ccw}, {3'b001, f[0]});
            put(7'h00);
            put(7'h02);
            check({2'b00, run, ccw}, {3'b001, !f[0]});
            put(7'h03);
            check({2'b00, decel_stop, run}, 4'h2);
            put(7'h04);
            check({1'b0, quick_stop, decel_stop, run}, 4'h0);
            put(7'h05);
            put(7'h04);
            put(7'h05);
            put(7'h07);
            check({1'b0, quick_stop, decel_stop, run}, 4'h4);
            put(7'h00);
        end
        for (int d = 0; d < 4; d++) begin
            put({2'b00, d[1:0], 3'b000});
            check(data_no, d[3:0]);
        end
        alarm_active <= 1'b1;
        put(7'h21);
        check({clr_n[2:0], run}, 4'h0);
        put(7'h00);
        put(7'h20);
        check(clr_n, 4'h1);
        put(7'h00);
        alarm_active <= 1'b0;
        put(7'h40);
        check({3'b000, brake_release}, 4'h1);
        put(7'h00);
        map_use_custom <= 1'b1;
        three_wire_mode <= 1'b1;
        term_func_map <= {mdid_pkg::FN_SEL3, mdid_pkg::FN_SEL2, mdid_pkg::FN_SEL1, mdid_pkg::FN_SEL0,
            mdid_pkg::FN_SPIN_SENSE, mdid_pkg::FN_QUICK_HALT, mdid_pkg::FN_RUN_GATE};
        put(7'h07);
        check({2'b00, run, ccw}, 4'h3);
        put(7'h06);
        check({3'b000, run}, 4'h0);
        put(7'h03);
        check({2'b00, run, ccw}, 4'h2);
        put(7'h01);
        check({3'b000, run}, 4'h0);
        for (int d = 0; d < 16; d++) begin
            put({d[3:0], 3'b000});
            check(data_no, d[3:0]);
        end
        put(7'h40);
        three_wire_mode <= 1'b0;
        term_func_map <= {mdid_pkg::FN_OUTSIDE_FAULT, mdid_pkg::FN_NOTICE_CLEAR, mdid_pkg::FN_PANEL_LOCKOUT,
            mdid_pkg::FN_TORQUE_CAP, mdid_pkg::FN_HOLD_DISABLE, mdid_pkg::FN_BACKWARD_RUN, mdid_pkg::FN_FORWARD_RUN};
        put(7'h5c);
        check({hold_disable, torque_limit, panel_locked, ext_alarm}, 4'he);
        put(7'h60);
        check(note_n, 4'h1);
        put(7'h00);
        put(7'h41);
        check({2'b00, ext_alarm, run}, 4'h2);
        give_verdict();
    end
endmodule : mdid_decoder_tb_top
`default_nettype wire
